// File: logic/bcs_config_space.sv
// How it works
// R01 - Only the primary-side configuration port reaches these registers; none face the secondary side.
// R02 - Accesses of one byte, one word or one doubleword are served, lanes picked by byte enables.
// R03 - Multi-byte fields are little-endian, the lowest address holding the least significant byte.
// R04 - Writes to read-only registers or fields change nothing and cause nothing.
// R05 - A write of one clears a status event bit, a write of zero leaves it, reads show its state.
// R06 - Every access, reserved locations included, is completed with an acknowledge.
// R07 - Software should not write reserved locations above the standard header.
// R08 - Software masks reserved bits on reads and writes them back unchanged on writes; the bench writes whole values without merging.
// R09 - While the hard reset is high every register holds its default.
// R10 - Registers revert to defaults while any dock, bus reset, power or suspend input reads low.
// R11 - Registers revert to defaults while either connector-detect input reads high.
// R12 - Fixed vendor and device codes are read from the first two words.
// R13 - The primary command register sits at bytes 04h-05h and is read/write.
// R14 - The three bus number registers are read/write bytes at 18h, 19h and 1Ah.
// R15 - The prefetch window base and limit are read/write words at 24h and 26h.
// R16 - Reserved locations and bits read as zero and writes to them are dropped.
`timescale 1ns/10ps
`include "bcs_map.svh"

module bcs_config_space
	import bcs_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = 16'hA5C3,
	parameter logic [15:0] DEVICE_CODE = 16'h5A3C,
	parameter logic [7:0] REVISION_CODE = 8'h00
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cfg_req,
	input wire logic cfg_wr,
	input wire logic [5:0] cfg_addr,
	input wire logic [3:0] cfg_be_n,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	input wire logic ev_signaled_system_error,
	input wire logic ev_received_master_abort,
	input wire logic ev_received_target_abort,
	input wire logic ev_signaled_target_abort,
	input wire logic battery_domain_reset_n,
	input wire logic primary_bus_reset_n,
	input wire logic station_power_good,
	input wire logic portable_power_ok,
	input wire logic portable_suspended_n,
	input wire logic connector_detect_one_n,
	input wire logic connector_detect_two_n,
	output logic [15:0] primary_command,
	output logic [7:0] upstream_bus_number,
	output logic [7:0] downstream_bus_number,
	output logic [7:0] highest_bus_number,
	output logic [15:0] prefetch_window_base,
	output logic [15:0] prefetch_window_limit
);

	bcs_state_t st_reg;
	bcs_state_t st_next;
	logic [6:0] pins_raw;
	logic [3:0] evt_in;
	logic revert_now;

	assign pins_raw = {connector_detect_two_n, connector_detect_one_n, portable_suspended_n,
		portable_power_ok, station_power_good, primary_bus_reset_n, battery_domain_reset_n};
	assign evt_in = {ev_signaled_system_error, ev_received_master_abort,
		ev_received_target_abort, ev_signaled_target_abort};

	// Filtered pin levels decide whether the bank is held at defaults.
	assign revert_now = (st_reg.pin_level[4:0] != `BCS_PIN_LIVE) // [R10]
		|| (st_reg.pin_level[6:5] != 2'h0); // [R11]

	function automatic bcs_state_t load_defaults(input bcs_state_t s);
		bcs_state_t t;
		t = s;
		t.cmd = `BCS_CMD_DEFAULT;
		t.pri_evt = 4'h0;
		t.mlt = `BCS_MLT_DEFAULT;
		t.up_bus = `BCS_RW8_DEFAULT;
		t.down_bus = `BCS_RW8_DEFAULT;
		t.top_bus = `BCS_RW8_DEFAULT;
		t.down_sts = `BCS_RW16_DEFAULT;
		t.pf_base = `BCS_RW16_DEFAULT;
		t.pf_limit = `BCS_RW16_DEFAULT;
		t.br_ctl = `BCS_RW16_DEFAULT;
		t.con_ctl = `BCS_RW8_DEFAULT;
		t.con_evt = `BCS_RW8_DEFAULT;
		t.sif = `BCS_RW16_DEFAULT;
		t.misc = `BCS_RW8_DEFAULT;
		t.spcyc = `BCS_RW16_DEFAULT;
		return t;
	endfunction : load_defaults

	function automatic logic [7:0] rd_byte(input bcs_state_t s, input logic [7:0] a);
		logic [7:0] v;
		logic [15:0] sts;
		v = 8'h00;
		sts = 16'h0000;
		sts[`BCS_STS_EVT_LSB + 8 +: 4] = s.pri_evt;
		sts[`BCS_STS_DEVSEL_LSB + 8 +: 2] = `BCS_STS_DEVSEL;
		case (a)
			`BCS_OFS_VENDOR: v = VENDOR_CODE[7:0]; // [R12] [R03]
			`BCS_OFS_VENDOR + 8'h01: v = VENDOR_CODE[15:8];
			`BCS_OFS_DEVICE: v = DEVICE_CODE[7:0]; // [R12]
			`BCS_OFS_DEVICE + 8'h01: v = DEVICE_CODE[15:8];
			`BCS_OFS_CMD: v = s.cmd[7:0]; // [R13]
			`BCS_OFS_CMD + 8'h01: v = s.cmd[15:8];
			`BCS_OFS_STS: v = sts[7:0]; // [R05]
			`BCS_OFS_STS + 8'h01: v = sts[15:8];
			`BCS_OFS_REV: v = REVISION_CODE;
			`BCS_OFS_CLASS: v = 8'(`BCS_CLASS_DEFAULT);
			`BCS_OFS_CLASS + 8'h01: v = 8'(`BCS_CLASS_DEFAULT >> 8);
			`BCS_OFS_CLASS + 8'h02: v = 8'(`BCS_CLASS_DEFAULT >> 16);
			`BCS_OFS_LINE: v = `BCS_LINE_DEFAULT;
			`BCS_OFS_MLT: v = s.mlt;
			`BCS_OFS_HDR: v = `BCS_HDR_DEFAULT;
			`BCS_OFS_UPBUS: v = s.up_bus; // [R14]
			`BCS_OFS_DNBUS: v = s.down_bus;
			`BCS_OFS_TOPBUS: v = s.top_bus;
			`BCS_OFS_DNSTS: v = s.down_sts[7:0];
			`BCS_OFS_DNSTS + 8'h01: v = s.down_sts[15:8];
			`BCS_OFS_PFBASE: v = s.pf_base[7:0]; // [R15]
			`BCS_OFS_PFBASE + 8'h01: v = s.pf_base[15:8];
			`BCS_OFS_PFLIM: v = s.pf_limit[7:0];
			`BCS_OFS_PFLIM + 8'h01: v = s.pf_limit[15:8];
			`BCS_OFS_BRCTL: v = s.br_ctl[7:0];
			`BCS_OFS_BRCTL + 8'h01: v = s.br_ctl[15:8];
			`BCS_OFS_CONCTL: v = s.con_ctl;
			`BCS_OFS_CONEVT: v = s.con_evt;
			`BCS_OFS_SIF: v = s.sif[7:0];
			`BCS_OFS_SIF + 8'h01: v = s.sif[15:8];
			`BCS_OFS_MISC: v = s.misc;
			`BCS_OFS_SPCYC: v = s.spcyc[7:0];
			`BCS_OFS_SPCYC + 8'h01: v = s.spcyc[15:8];
			default: v = 8'h00; // [R16]
		endcase
		return v;
	endfunction : rd_byte

	function automatic bcs_state_t wr_byte(input bcs_state_t s, input logic [7:0] a,
		input logic [7:0] d);
		bcs_state_t t;
		t = s;
		case (a)
			`BCS_OFS_CMD: t.cmd[7:0] = (d & 8'(`BCS_CMD_WMASK)) // [R13]
				| (s.cmd[7:0] & ~8'(`BCS_CMD_WMASK));
			`BCS_OFS_CMD + 8'h01: t.cmd[15:8] = (d & 8'(`BCS_CMD_WMASK >> 8))
				| (s.cmd[15:8] & ~8'(`BCS_CMD_WMASK >> 8));
			`BCS_OFS_STS + 8'h01: t.pri_evt = s.pri_evt & ~d[`BCS_STS_EVT_LSB +: 4]; // [R05]
			`BCS_OFS_MLT: t.mlt = d;
			`BCS_OFS_UPBUS: t.up_bus = d; // [R14]
			`BCS_OFS_DNBUS: t.down_bus = d;
			`BCS_OFS_TOPBUS: t.top_bus = d;
			`BCS_OFS_DNSTS: t.down_sts[7:0] = d;
			`BCS_OFS_DNSTS + 8'h01: t.down_sts[15:8] = d;
			`BCS_OFS_PFBASE: t.pf_base[7:0] = d; // [R15] [R03]
			`BCS_OFS_PFBASE + 8'h01: t.pf_base[15:8] = d;
			`BCS_OFS_PFLIM: t.pf_limit[7:0] = d;
			`BCS_OFS_PFLIM + 8'h01: t.pf_limit[15:8] = d;
			`BCS_OFS_BRCTL: t.br_ctl[7:0] = d;
			`BCS_OFS_BRCTL + 8'h01: t.br_ctl[15:8] = d;
			`BCS_OFS_CONCTL: t.con_ctl = d;
			`BCS_OFS_CONEVT: t.con_evt = d;
			`BCS_OFS_SIF: t.sif[7:0] = d;
			`BCS_OFS_SIF + 8'h01: t.sif[15:8] = d;
			`BCS_OFS_MISC: t.misc = d;
			`BCS_OFS_SPCYC: t.spcyc[7:0] = d;
			`BCS_OFS_SPCYC + 8'h01: t.spcyc[15:8] = d;
			default: t = s; // [R04] [R16]
		endcase
		return t;
	endfunction : wr_byte

	always_comb begin
		st_next = st_reg;
		st_next.sync1 = pins_raw;
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		if (st_reg.sync2 == st_reg.sync3) begin
			st_next.pin_level = st_reg.sync3;
		end
		st_next.ack = cfg_req; // [R06] [R01]
		if (cfg_req && !cfg_wr) begin
			for (int i = 0; i < 4; i++) begin
				st_next.rdata[8 * i +: 8] = rd_byte(st_reg, {cfg_addr, 2'(i)}); // [R03]
			end
		end
		if (cfg_req && cfg_wr) begin
			for (int i = 0; i < 4; i++) begin
				if (!cfg_be_n[i]) begin
					st_next = wr_byte(st_next, {cfg_addr, 2'(i)}, cfg_wdata[8 * i +: 8]); // [R02]
				end
			end
		end
		st_next.pri_evt = st_next.pri_evt | evt_in;
		if (revert_now) begin
			st_next = load_defaults(st_next); // [R10] [R11]
		end
		if (sys_rst) begin
			st_next = load_defaults(st_next); // [R09]
			st_next.sync1 = `BCS_PIN_IDLE;
			st_next.sync2 = `BCS_PIN_IDLE;
			st_next.sync3 = `BCS_PIN_IDLE;
			st_next.pin_level = `BCS_PIN_IDLE;
			st_next.ack = 1'b0;
			st_next.rdata = 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys) begin
		st_reg <= st_next;
	end

	assign cfg_ack = st_reg.ack;
	assign cfg_rdata = st_reg.rdata;
	assign primary_command = st_reg.cmd;
	assign upstream_bus_number = st_reg.up_bus;
	assign downstream_bus_number = st_reg.down_bus;
	assign highest_bus_number = st_reg.top_bus;
	assign prefetch_window_base = st_reg.pf_base;
	assign prefetch_window_limit = st_reg.pf_limit;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	a_ack_every_req: assert property (cfg_req |=> cfg_ack) // [R06]
		else $error("Access was not completed.");
	a_ident_words: assert property (cfg_req && !cfg_wr && cfg_addr == 6'h00 // [R12]
		|=> cfg_rdata == {DEVICE_CODE, VENDOR_CODE})
		else $error("Identification words read wrong.");
	a_cmd_fixed_one: assert property (cfg_req && !cfg_wr && cfg_addr == 6'h01 // [R13]
		|=> cfg_rdata[7] && cfg_rdata[26:25] == `BCS_STS_DEVSEL)
		else $error("Fixed command or status bits read wrong.");
	a_class_fixed: assert property (cfg_req && !cfg_wr && cfg_addr == 6'h02 // [R04]
		|=> cfg_rdata == {`BCS_CLASS_DEFAULT, REVISION_CODE})
		else $error("Class code or revision changed.");
	a_clear_on_one: assert property (cfg_req && cfg_wr && cfg_addr == 6'h01 // [R05]
		&& !cfg_be_n[3] && cfg_wdata[30] && !ev_signaled_system_error
		|=> !st_reg.pri_evt[3])
		else $error("Write of one did not clear the event.");
	a_keep_on_zero: assert property (st_reg.pri_evt[3] && !revert_now // [R05]
		&& !(cfg_req && cfg_wr && cfg_addr == 6'h01 && !cfg_be_n[3] && cfg_wdata[30])
		|=> st_reg.pri_evt[3])
		else $error("Event bit lost without a write of one.");
	a_event_wins: assert property (ev_signaled_system_error && !revert_now // [R05]
		|=> st_reg.pri_evt[3])
		else $error("Event lost against a clear.");
	a_hard_reset: assert property (@(posedge clk_sys) disable iff (1'b0) // [R09]
		sys_rst |=> st_reg.cmd == `BCS_CMD_DEFAULT && st_reg.up_bus == 8'h00
		&& st_reg.pri_evt == 4'h0 && !cfg_ack)
		else $error("Hard reset left a register off its default.");
	a_pins_revert: assert property (revert_now // [R10] [R11]
		|=> st_reg.pf_base == `BCS_RW16_DEFAULT && st_reg.top_bus == `BCS_RW8_DEFAULT
		&& st_reg.cmd == `BCS_CMD_DEFAULT)
		else $error("Pin condition did not restore defaults.");
	a_bus_numbers: assert property (cfg_req && cfg_wr && cfg_addr == 6'h06 // [R14]
		&& cfg_be_n == 4'h8 && !revert_now
		|=> st_reg.up_bus == $past(cfg_wdata[7:0]) && st_reg.down_bus == $past(cfg_wdata[15:8])
		&& st_reg.top_bus == $past(cfg_wdata[23:16]))
		else $error("Bus number bytes not stored.");
	a_prefetch_words: assert property (cfg_req && cfg_wr && cfg_addr == 6'h09 // [R15]
		&& cfg_be_n == 4'h0 && !revert_now
		|=> st_reg.pf_base == $past(cfg_wdata[15:0]) && st_reg.pf_limit == $past(cfg_wdata[31:16]))
		else $error("Prefetch window words not stored.");
	a_reserved_zero: assert property (cfg_req && !cfg_wr && cfg_addr == 6'h04 // [R16]
		|=> cfg_ack && cfg_rdata == 32'h00000000)
		else $error("Reserved location read nonzero.");
	c_byte_write: cover property (cfg_req && cfg_wr && $countones(~cfg_be_n) == 1);
	c_event_cleared: cover property (st_reg.pri_evt[0] ##1 !st_reg.pri_evt[0]);
	c_dock_revert: cover property (!revert_now ##1 revert_now);

endmodule : bcs_config_space

// File: logic/bcs_map.svh
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
`define BCS_OFS_VENDOR 8'h00
`define BCS_OFS_DEVICE 8'h02
`define BCS_OFS_CMD 8'h04
`define BCS_OFS_STS 8'h06
`define BCS_OFS_REV 8'h08
`define BCS_OFS_CLASS 8'h09
`define BCS_OFS_LINE 8'h0C
`define BCS_OFS_MLT 8'h0D
`define BCS_OFS_HDR 8'h0E
`define BCS_OFS_UPBUS 8'h18
`define BCS_OFS_DNBUS 8'h19
`define BCS_OFS_TOPBUS 8'h1A
`define BCS_OFS_DNSTS 8'h1E
`define BCS_OFS_PFBASE 8'h24
`define BCS_OFS_PFLIM 8'h26
`define BCS_OFS_BRCTL 8'h3E
`define BCS_OFS_CONCTL 8'h40
`define BCS_OFS_CONEVT 8'h41
`define BCS_OFS_SIF 8'h44
`define BCS_OFS_MISC 8'h46
`define BCS_OFS_SPCYC 8'h4C
`define BCS_CMD_DEFAULT 16'h0080
`define BCS_CMD_WMASK 16'h0107
`define BCS_STS_EVT_LSB 3
`define BCS_STS_DEVSEL 2'h2
`define BCS_STS_DEVSEL_LSB 1
`define BCS_CLASS_DEFAULT 24'h060480
`define BCS_LINE_DEFAULT 8'h08
`define BCS_HDR_DEFAULT 8'h01
`define BCS_MLT_DEFAULT 8'h00
`define BCS_RW8_DEFAULT 8'h00
`define BCS_RW16_DEFAULT 16'h0000
`define BCS_PIN_IDLE 7'h60
`define BCS_PIN_LIVE 5'h1F
`endif

// File: logic/bcs_pkg.sv
package bcs_pkg;
	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [6:0] sync3;
		logic [6:0] pin_level;
		logic [15:0] cmd;
		logic [3:0] pri_evt;
		logic [7:0] mlt;
		logic [7:0] up_bus;
		logic [7:0] down_bus;
		logic [7:0] top_bus;
		logic [15:0] down_sts;
		logic [15:0] pf_base;
		logic [15:0] pf_limit;
		logic [15:0] br_ctl;
		logic [7:0] con_ctl;
		logic [7:0] con_evt;
		logic [15:0] sif;
		logic [7:0] misc;
		logic [15:0] spcyc;
		logic ack;
		logic [31:0] rdata;
	} bcs_state_t;
endpackage : bcs_pkg

// File: verif/bcs_master_model.sv
`timescale 1ns/10ps
module bcs_master_model (
	input wire logic clk_sys,
	output logic cfg_req,
	output logic cfg_wr,
	output logic [5:0] cfg_addr,
	output logic [3:0] cfg_be_n,
	output logic [31:0] cfg_wdata,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata
);
	initial begin
		cfg_req = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 6'h00;
		cfg_be_n = 4'hF;
		cfg_wdata = 32'h0;
	end
	// Callers write whole values without reading and merging first; no reserved place above 3Fh is written.
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [3:0] be_n,
		input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clk_sys);
		cfg_req <= 1'b1;
		cfg_wr <= wr;
		cfg_addr <= a;
		cfg_be_n <= be_n;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_req <= 1'b0;
		cfg_wdata <= ~d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cfg_ack !== 1'b1 && n < 4);
		q = (cfg_ack === 1'b1) ? cfg_rdata : 32'hx;
	endtask : xfer
endmodule : bcs_master_model

// File: verif/bridge_config_space_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) check(g, e)
module bridge_config_space_bench;
	logic clk_sys, sys_rst, cfg_req, cfg_wr, cfg_ack;
	logic [5:0] cfg_addr;
	logic [3:0] cfg_be_n, ev;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [6:0] pins;
	logic [15:0] cmd, pfb, pfl;
	logic [7:0] upb, dnb, hib;
	int fails = 0, comparisons = 0, cycles = 0;
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		sys_rst = 1'b1;
		ev = 4'h0;
		pins = 7'h1F;
	end
	bcs_config_space i_bcs_config_space (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n),
		.cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.ev_signaled_system_error(ev[3]), .ev_received_master_abort(ev[2]),
		.ev_received_target_abort(ev[1]), .ev_signaled_target_abort(ev[0]),
		.battery_domain_reset_n(pins[0]), .primary_bus_reset_n(pins[1]),
		.station_power_good(pins[2]), .portable_power_ok(pins[3]),
		.portable_suspended_n(pins[4]), .connector_detect_one_n(pins[5]),
		.connector_detect_two_n(pins[6]), .primary_command(cmd),
		.upstream_bus_number(upb), .downstream_bus_number(dnb), .highest_bus_number(hib),
		.prefetch_window_base(pfb), .prefetch_window_limit(pfl));
	bcs_master_model i_bcs_master_model (.clk_sys(clk_sys), .cfg_req(cfg_req),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata),
		.cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic wr(input logic [5:0] a, input logic [3:0] be_n, input logic [31:0] d);
		logic [31:0] q;
		i_bcs_master_model.xfer(1'b1, a, be_n, d, q);
		`CHK({31'h0, q === 32'hx}, 32'h0);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		i_bcs_master_model.xfer(1'b0, a, 4'h0, 32'h0, q);
		`CHK(q, e);
	endtask : rd
	task automatic stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rd(6'h00, 32'h5A3C_A5C3);
		rd(6'h01, 32'h0400_0080);
		rd(6'h03, 32'h0001_0008);
		wr(6'h00, 4'h0, 32'hFFFF_FFFF);
		wr(6'h02, 4'h0, 32'h0);
		rd(6'h00, 32'h5A3C_A5C3);
		rd(6'h02, 32'h0604_8000);
		$display("test identity done");
		wr(6'h06, 4'h8, 32'h0003_0201);
		rd(6'h06, 32'h0003_0201);
		`CHK({8'h0, hib, dnb, upb}, 32'h0003_0201);
		wr(6'h06, 4'hD, 32'hFFFF_AAFF);
		rd(6'h06, 32'h0003_AA01);
		wr(6'h01, 4'hC, 32'hFFFF_FFFF);
		rd(6'h01, 32'h0400_0187);
		`CHK({16'h0, cmd}, 32'h0000_0187);
		wr(6'h09, 4'h0, 32'h1234_5678);
		rd(6'h09, 32'h1234_5678);
		`CHK({pfl, pfb}, 32'h1234_5678);
		$display("test read write done");
		@(posedge clk_sys) ev <= 4'hF;
		@(posedge clk_sys) ev <= 4'h0;
		rd(6'h01, 32'h7C00_0187);
		wr(6'h01, 4'h7, 32'h4000_0000);
		rd(6'h01, 32'h3C00_0187);
		wr(6'h01, 4'h3, 32'h0000_0000);
		rd(6'h01, 32'h3C00_0187);
		wr(6'h01, 4'h7, 32'h3800_0000);
		rd(6'h01, 32'h0400_0187);
		wr(6'h05, 4'h0, 32'hFFFF_FFFF);
		rd(6'h05, 32'h0);
		rd(6'h3F, 32'h0);
		$display("test status reserved done");
		for (int i = 0; i < 7; i++) begin
			wr(6'h06, 4'h8, 32'h0003_0201);
			pins <= 7'h1F ^ (7'h01 << i);
			repeat (8) @(posedge clk_sys);
			wr(6'h06, 4'h8, 32'h0009_0909);
			pins <= 7'h1F;
			repeat (8) @(posedge clk_sys);
			rd(6'h06, 32'h0);
		end
		$display("test revert done");
		wr(6'h06, 4'h8, 32'h0003_0201);
		wr(6'h01, 4'hC, 32'hFFFF_FFFF);
		rd(6'h01, 32'h0400_0187);
		sys_rst <= 1'b1;
		@(posedge clk_sys) sys_rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rd(6'h06, 32'h0);
		rd(6'h01, 32'h0400_0080);
		$display("test hard reset done");
		stop_test();
	end
endmodule : bridge_config_space_bench
